//--- design/mta_pkg.sv
// package of constants and types for the multi-tile alignment block
// ****************************************
// Overview of operation
// ****************************************
package mta_pkg;
    localparam int DATA_W = 16;
    localparam int CNT_W = 8;
    localparam int MAX_CH = 16;
    localparam int FIFO_DEPTH = 16;
    // one word carries one sample, so one step is one sample period
    localparam int SAMPLE_PERIOD_PS = 5000;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int STEP_WORDS = SAMPLE_PERIOD_PS / CLK_PERIOD_PS;
    localparam int MEAS_TIMEOUT_CYC = 4096;
    localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
    localparam logic [DATA_W-1:0] UPD_RST = 16'h0000;

    typedef struct packed {
        logic marker;
        logic [DATA_W-1:0] data;
    } mta_word_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_BLK,
        ST_MEAS,
        ST_ADJ,
        ST_HOLD
    } mta_state_t;
endpackage

//--- design/mta_fifo.sv
// gearbox fifo with registered read data and honest full and empty
`timescale 1ns/1ps
module mta_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 16
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic ov_r, ov_nxt;
    logic [WIDTH-1:0] od_r, od_nxt;
    logic push, pop;

    assign in_ready = cnt_r < (AW+1)'(DEPTH);
    assign out_valid = ov_r;
    assign out_data = od_r;

    always_comb begin
        push = in_valid && in_ready;
        pop = (cnt_r != '0) && (!ov_r || out_ready);
        wp_nxt = push ? wp_r + 1'b1 : wp_r;
        rp_nxt = pop ? rp_r + 1'b1 : rp_r;
        cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        ov_nxt = pop ? 1'b1 : (out_ready ? 1'b0 : ov_r);
        od_nxt = pop ? mem[rp_r] : od_r;
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
        if (sys_rst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            ov_r <= 1'b0;
            od_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
            ov_r <= ov_nxt;
            od_r <= od_nxt;
        end
    end
endmodule // mta_fifo

//--- design/mta_align.sv
// multi-tile fifo latency measurement and alignment
`timescale 1ns/1ps
module mta_align #(
    parameter int NCH = 4,
    parameter int MEAS_TIMEOUT = mta_pkg::MEAS_TIMEOUT_CYC
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic [NCH-1:0] chan_sel,
    input wire logic [mta_pkg::CNT_W-1:0] target_lat,
    input wire logic conv_ref,
    input wire logic fabric_timing_ref,
    input wire logic [NCH-1:0] src_valid,
    output logic [NCH-1:0] src_ready,
    input wire logic [NCH*mta_pkg::DATA_W-1:0] src_data,
    output logic [NCH-1:0] snk_valid,
    input wire logic [NCH-1:0] snk_ready,
    output logic [NCH*mta_pkg::DATA_W-1:0] snk_data,
    output logic busy,
    output logic done,
    output logic timeout,
    output logic block_align,
    output logic [NCH*mta_pkg::CNT_W-1:0] meas_counts,
    input wire logic upd_arm,
    input wire logic [mta_pkg::DATA_W-1:0] upd_word,
    output logic [mta_pkg::DATA_W-1:0] upd_active
);
    localparam int CW = mta_pkg::CNT_W;
    localparam int DW = mta_pkg::DATA_W;
    localparam int TW = $clog2(MEAS_TIMEOUT + 1);
    localparam int WW = $bits(mta_pkg::mta_word_t);

    // ****************************************
    // reference synchronisers and edge detect
    // ****************************************
    logic [2:0] cref_r, cref_nxt, fref_r, fref_nxt;
    logic crise, frise;

    always_comb begin
        cref_nxt = {cref_r[1:0], conv_ref};
        fref_nxt = {fref_r[1:0], fabric_timing_ref};
        crise = cref_r[1] && !cref_r[2];
        frise = fref_r[1] && !fref_r[2];
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cref_r <= 3'h0;
            fref_r <= 3'h0;
        end else begin
            cref_r <= cref_nxt;
            fref_r <= fref_nxt;
        end
    end

    // ****************************************
    // per channel fifos
    // ****************************************
    // each channel has its own fifo; a dac path simply swaps who feeds src
    mta_pkg::mta_word_t fin [NCH];
    mta_pkg::mta_word_t fout [NCH];
    logic [NCH-1:0] fout_valid, fout_ready, mark_pend_r, mark_pend_nxt;
    logic [CW-1:0] hold_r [NCH];
    logic [CW-1:0] hold_nxt [NCH];

    // one process for all lanes, so no vector has several drivers
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            fin[i].marker = mark_pend_r[i];
            fin[i].data = src_data[i*DW +: DW];
            // pointer adjustment: reads held back while hold count is nonzero
            snk_valid[i] = fout_valid[i] && (hold_r[i] == '0);
            fout_ready[i] = snk_ready[i] && (hold_r[i] == '0);
            snk_data[i*DW +: DW] = fout[i].data;
        end
    end

    for (genvar g = 0; g < NCH; g++) begin : g_ch
        mta_fifo #(
            .WIDTH(WW),
            .DEPTH(mta_pkg::FIFO_DEPTH)
        ) u_fifo (
            .core_clk(core_clk),
            .sys_rst(sys_rst),
            .in_valid(src_valid[g]),
            .in_ready(src_ready[g]),
            .in_data(fin[g]),
            .out_valid(fout_valid[g]),
            .out_ready(fout_ready[g]),
            .out_data(fout[g])
        );
    end

    // ****************************************
    // measurement counters
    // ****************************************
    logic [CW-1:0] cnt_r [NCH];
    logic [CW-1:0] cnt_nxt [NCH];
    logic [NCH-1:0] stop_r, stop_nxt;
    logic [NCH-1:0] mark_arm_r, mark_arm_nxt;
    mta_pkg::mta_state_t st_r, st_nxt;

    function automatic logic [CW-1:0] max_cnt(
        input logic [CW-1:0] c [NCH],
        input logic [NCH-1:0] sel
    );
        logic [CW-1:0] m;
        m = '0;
        for (int i = 0; i < NCH; i++) begin
            if (sel[i] && c[i] > m) begin
                m = c[i];
            end
        end
        return m;
    endfunction

    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            cnt_nxt[i] = cnt_r[i];
            stop_nxt[i] = stop_r[i];
            mark_arm_nxt[i] = mark_arm_r[i];
            mark_pend_nxt[i] = mark_pend_r[i];
            if (st_r == mta_pkg::ST_MEAS && chan_sel[i]) begin
                // converter edge tags the next written word as the marker
                if (crise && !mark_arm_r[i]) begin
                    mark_arm_nxt[i] = 1'b1;
                    mark_pend_nxt[i] = 1'b1;
                end
                if (mark_pend_r[i] && src_valid[i] && src_ready[i]) begin
                    mark_pend_nxt[i] = 1'b0;
                end
                if (!stop_r[i]) begin
                    if (frise) begin
                        cnt_nxt[i] = mta_pkg::CNT_RST;
                    end else if (fout_valid[i] && fout_ready[i]) begin
                        cnt_nxt[i] = cnt_r[i] + 1'b1;
                    end
                    if (fout_valid[i] && fout_ready[i] && fout[i].marker) begin
                        stop_nxt[i] = 1'b1;
                    end
                end
            end else if (st_r == mta_pkg::ST_BLK) begin
                cnt_nxt[i] = mta_pkg::CNT_RST;
                stop_nxt[i] = 1'b0;
                mark_arm_nxt[i] = 1'b0;
                mark_pend_nxt[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < NCH; i++) begin
                cnt_r[i] <= mta_pkg::CNT_RST;
            end
            stop_r <= '0;
            mark_arm_r <= '0;
            mark_pend_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
            stop_r <= stop_nxt;
            mark_arm_r <= mark_arm_nxt;
            mark_pend_r <= mark_pend_nxt;
        end
    end

    // ****************************************
    // alignment sequencer
    // ****************************************
    logic [TW-1:0] tmo_r, tmo_nxt;
    logic done_r, done_nxt, tmo_flag_r, tmo_flag_nxt, blk_r, blk_nxt;
    logic [CW-1:0] tgt;
    logic [CW-1:0] meas_r [NCH];
    logic [CW-1:0] meas_nxt [NCH];

    always_comb begin
        st_nxt = st_r;
        tmo_nxt = tmo_r;
        done_nxt = 1'b0;
        tmo_flag_nxt = tmo_flag_r;
        blk_nxt = 1'b0;
        meas_nxt = meas_r;
        tgt = max_cnt(cnt_r, chan_sel);
        if (target_lat > tgt) begin
            tgt = target_lat;
        end
        for (int i = 0; i < NCH; i++) begin
            hold_nxt[i] = hold_r[i];
            if (hold_r[i] != '0 && fout_valid[i]) begin
                hold_nxt[i] = hold_r[i] - CW'(mta_pkg::STEP_WORDS);
            end
        end
        case (st_r)
            mta_pkg::ST_IDLE: begin
                if (start) begin
                    tmo_flag_nxt = 1'b0;
                    st_nxt = mta_pkg::ST_BLK;
                end
            end
            mta_pkg::ST_BLK: begin
                // synchronous blocks restart on the converter edge first
                if (crise) begin
                    blk_nxt = 1'b1;
                    tmo_nxt = '0;
                    st_nxt = mta_pkg::ST_MEAS;
                end
            end
            mta_pkg::ST_MEAS: begin
                tmo_nxt = tmo_r + 1'b1;
                if ((stop_r & chan_sel) == chan_sel) begin
                    st_nxt = mta_pkg::ST_ADJ;
                end else if (tmo_r == TW'(MEAS_TIMEOUT)) begin
                    tmo_flag_nxt = 1'b1;
                    done_nxt = 1'b1;
                    st_nxt = mta_pkg::ST_IDLE;
                end
            end
            mta_pkg::ST_ADJ: begin
                for (int i = 0; i < NCH; i++) begin
                    meas_nxt[i] = cnt_r[i];
                    if (chan_sel[i]) begin
                        hold_nxt[i] = tgt - cnt_r[i];
                    end
                end
                st_nxt = mta_pkg::ST_HOLD;
            end
            mta_pkg::ST_HOLD: begin
                st_nxt = mta_pkg::ST_IDLE;
                done_nxt = 1'b1;
                for (int i = 0; i < NCH; i++) begin
                    if (hold_r[i] != '0) begin
                        st_nxt = mta_pkg::ST_HOLD;
                        done_nxt = 1'b0;
                    end
                end
            end
            default: begin
                st_nxt = mta_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_r <= mta_pkg::ST_IDLE;
            tmo_r <= '0;
            done_r <= 1'b0;
            tmo_flag_r <= 1'b0;
            blk_r <= 1'b0;
            for (int i = 0; i < NCH; i++) begin
                hold_r[i] <= mta_pkg::CNT_RST;
                meas_r[i] <= mta_pkg::CNT_RST;
            end
        end else begin
            st_r <= st_nxt;
            tmo_r <= tmo_nxt;
            done_r <= done_nxt;
            tmo_flag_r <= tmo_flag_nxt;
            blk_r <= blk_nxt;
            hold_r <= hold_nxt;
            meas_r <= meas_nxt;
        end
    end

    // ****************************************
    // on the fly update and status
    // ****************************************
    logic [DW-1:0] upd_r, upd_nxt;

    always_comb begin
        upd_nxt = upd_r;
        // same edge in every tile, so the new word lands everywhere at once
        if (upd_arm && crise) begin
            upd_nxt = upd_word;
        end
        for (int i = 0; i < NCH; i++) begin
            meas_counts[i*CW +: CW] = meas_r[i];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            upd_r <= mta_pkg::UPD_RST;
        end else begin
            upd_r <= upd_nxt;
        end
    end

    assign upd_active = upd_r;
    assign busy = (st_r != mta_pkg::ST_IDLE);
    assign done = done_r;
    assign timeout = tmo_flag_r;
    assign block_align = blk_r;
endmodule // mta_align

//--- dv/mta_align_sva.sv
// concurrent checks on the ports of the multi-tile alignment block
`timescale 1ns/1ps
module mta_align_sva #(
    parameter int NCH = 4
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic [NCH-1:0] snk_valid,
    input wire logic [NCH-1:0] snk_ready,
    input wire logic [NCH*mta_pkg::DATA_W-1:0] snk_data,
    input wire logic busy,
    input wire logic done,
    input wire logic timeout,
    input wire logic block_align,
    input wire logic [NCH*mta_pkg::CNT_W-1:0] meas_counts,
    input wire logic upd_arm,
    input wire logic [mta_pkg::DATA_W-1:0] upd_word,
    input wire logic [mta_pkg::DATA_W-1:0] upd_active
);
    // **********
    // properties
    // **********
    // bound covers the reference wait, the timeout and the hold phase
    localparam int RUN_MAX = 1000;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence s_launch;
        start && !busy;
    endsequence
    sequence s_strobe;
        ##[1:RUN_MAX] block_align;
    endsequence
    sequence s_finish;
        ##[1:RUN_MAX] done;
    endsequence
    launch_busy_a: assert property (s_launch |=> busy)
        else $error("start in idle did not raise busy");
    launch_strobe_a: assert property (s_launch |-> s_strobe)
        else $error("no block restart strobe after start");
    launch_done_a: assert property (s_launch |-> s_finish)
        else $error("alignment did not finish in time");
    strobe_busy_a: assert property (block_align |-> busy)
        else $error("block strobe outside an alignment run");
    done_pulse_a: assert property (done |=> !done)
        else $error("done wider than one cycle");
    timeout_done_a: assert property ($rose(timeout) |-> done)
        else $error("timeout raised without done");
    counts_busy_a: assert property (!$stable(meas_counts) |-> busy)
        else $error("counts changed outside an alignment run");
    update_load_a: assert property (!$stable(upd_active) |->
        upd_active == $past(upd_word) && $past(upd_arm))
        else $error("update word applied without arm");
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        sink_hold_a: assert property (
            snk_valid[i] && !snk_ready[i] && !busy |=> snk_valid[i] &&
            $stable(snk_data[i*mta_pkg::DATA_W +: mta_pkg::DATA_W]))
            else $error("stalled sink word not held");
    end
endmodule // mta_align_sva

bind mta_align mta_align_sva #(.NCH(NCH)) u_sva (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .start(start),
    .snk_valid(snk_valid),
    .snk_ready(snk_ready),
    .snk_data(snk_data),
    .busy(busy),
    .done(done),
    .timeout(timeout),
    .block_align(block_align),
    .meas_counts(meas_counts),
    .upd_arm(upd_arm),
    .upd_word(upd_word),
    .upd_active(upd_active)
);

//--- dv/mta_fab_sink.sv
// fabric-side consumer model for the aligned sample streams
`timescale 1ns/1ps
module mta_fab_sink #(
    parameter int NCH = 4
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic stall,
    input wire logic choppy,
    output logic [NCH-1:0] snk_ready
);
    // **********
    // consumer
    // **********
    integer seed = 32'h63fc699d;
    // ready drops at random so held words get exercised
    always @(posedge core_clk) begin
        if (sys_rst || stall) begin
            snk_ready <= '0;
        end else if (choppy) begin
            snk_ready <= NCH'($random(seed));
        end else begin
            snk_ready <= '1;
        end
    end
endmodule // mta_fab_sink

//--- dv/tb_multi_tile_fifo_latency_alignment.sv
// self-checking bench for the multi-tile alignment block
`timescale 1ns/1ps
module tb_multi_tile_fifo_latency_alignment;
    // **********
    // signals
    // **********
    localparam int NCH = 4;
    localparam int DW = mta_pkg::DATA_W;
    localparam int WD_CYC = 20000;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic start = 1'b0;
    logic [NCH-1:0] chan_sel = '1;
    logic [7:0] target_lat = 8'h00;
    logic conv_ref = 1'b0;
    logic fabric_timing_ref = 1'b0;
    logic [NCH-1:0] src_valid = '0;
    logic [NCH-1:0] src_ready, snk_valid, snk_ready;
    logic [NCH*DW-1:0] src_data = '0;
    logic [NCH*DW-1:0] snk_data;
    logic busy, done, timeout, block_align;
    logic [NCH*8-1:0] meas_counts;
    logic upd_arm = 1'b0;
    logic [DW-1:0] upd_word = 16'h0000;
    logic [DW-1:0] upd_active;
    logic stall = 1'b1, choppy = 1'b0, lock = 1'b0, blk_seen = 1'b0;
    logic [DW-1:0] stamp = 16'h0001;
    logic [DW-1:0] last [NCH] = '{default: 16'h0000};
    integer seed = 32'h63fc699d;
    int n_mismatch = 0, compares = 0, acc = 0;

    initial forever #2.5 core_clk = ~core_clk;

    mta_align #(.NCH(NCH), .MEAS_TIMEOUT(200)) dut (.core_clk(core_clk),
        .sys_rst(sys_rst), .start(start), .chan_sel(chan_sel),
        .target_lat(target_lat), .conv_ref(conv_ref),
        .fabric_timing_ref(fabric_timing_ref), .src_valid(src_valid),
        .src_ready(src_ready), .src_data(src_data), .snk_valid(snk_valid),
        .snk_ready(snk_ready), .snk_data(snk_data), .busy(busy),
        .done(done), .timeout(timeout), .block_align(block_align),
        .meas_counts(meas_counts), .upd_arm(upd_arm), .upd_word(upd_word),
        .upd_active(upd_active));
    mta_fab_sink #(.NCH(NCH)) u_sink (.core_clk(core_clk),
        .sys_rst(sys_rst), .stall(stall), .choppy(choppy),
        .snk_ready(snk_ready));

    task automatic chk(string nm, logic [DW-1:0] e, logic [DW-1:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h got %h", nm, e, g);
        end
    endtask

    task automatic print_verdict;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic drain;
        @(posedge core_clk);
        stall <= 1'b0;
        choppy <= 1'b0;
        // release only once every offered word has been taken
        for (int n = 0; n < 100 && (src_valid & ~src_ready) != '0; n++)
            @(posedge core_clk);
        src_valid <= '0;
        repeat (4) @(negedge core_clk);
        for (int n = 0; n < 100 && snk_valid !== '0; n++) @(negedge core_clk);
        chk("drained", 16'h00f0, {8'h00, src_ready, snk_valid});
    endtask

    task automatic run_align;
        @(posedge core_clk);
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        for (int n = 0; n < 2000 && done !== 1'b1; n++) @(negedge core_clk);
        chk("done_seen", 16'h1, {15'h0, done});
        @(negedge core_clk);
    endtask

    // stamps rise every cycle, so each lane must deliver them increasing;
    // words written in the same cycle must leave together once aligned
    always @(posedge core_clk) begin
        conv_ref <= stamp[4:0] >= 5'h10 && stamp[4:0] < 5'h14;
        fabric_timing_ref <= stamp[4:2] == 3'h1;
        stamp <= stamp + 16'h0001;
        // a refused word stays on its lane until the fifo takes it
        for (int i = 0; i < NCH; i++)
            if (!src_valid[i] || src_ready[i])
                src_data[i*DW+:DW] <= stamp;
        blk_seen <= blk_seen | block_align;
    end
    always @(negedge core_clk) begin
        for (int i = 0; i < NCH; i++) begin
            if (!sys_rst && snk_valid[i] && snk_ready[i]) begin
                chk("order", 16'h1, 16'(snk_data[i*DW+:DW] > last[i]));
                last[i] = snk_data[i*DW+:DW];
            end
            if (lock && &snk_valid)
                chk("skew", snk_data[DW-1:0], snk_data[i*DW+:DW]);
        end
    end

    initial begin
        #(WD_CYC * 5);
        n_mismatch++;
        print_verdict();
    end

    initial begin
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(negedge core_clk);
        chk("idle", 16'h000f, {9'h0, busy, done, timeout, src_ready});
        chk("counts", 16'h0, meas_counts[15:0] | meas_counts[31:16]);
        chk("upd_rst", 16'h0, upd_active);
        // fill with the consumer stalled until every lane refuses
        @(posedge core_clk);
        src_valid <= '1;
        repeat (24) begin
            @(negedge core_clk);
            acc += int'(src_ready[0]);
        end
        chk("fill", 16'h1, 16'(acc >= 16 && acc <= 17));
        chk("full", 16'h0, 16'(src_ready));
        drain();
        choppy <= 1'b1;
        repeat (300) begin
            @(posedge core_clk);
            src_valid <= (src_valid & ~src_ready) | 4'($random(seed));
        end
        upd_word <= 16'($random(seed));
        upd_arm <= 1'b1;
        repeat (40) @(negedge core_clk);
        chk("update", upd_word, upd_active);
        @(posedge core_clk);
        upd_arm <= 1'b0;
        upd_word <= ~upd_word;
        repeat (40) @(negedge core_clk);
        chk("no_update", ~upd_word, upd_active);
        drain();
        // lanes start staggered so their buffered depth differs
        @(posedge core_clk);
        stall <= 1'b1;
        target_lat <= 8'h18;
        for (int k = 0; k < NCH; k++) begin
            @(posedge core_clk);
            src_valid[NCH-1-k] <= 1'b1;
        end
        @(posedge core_clk);
        stall <= 1'b0;
        run_align();
        chk("aligned", 16'h1, {15'h0, blk_seen & ~timeout});
        // lane i started i cycles before lane 0, so it measures i more
        for (int i = 1; i < NCH; i++)
            chk("skew_cnt", 16'(i),
                16'(meas_counts[i*8+:8] - meas_counts[7:0]));
        repeat (40) @(negedge core_clk);
        lock = 1'b1;
        repeat (100) @(negedge core_clk);
        lock = 1'b0;
        drain();
        @(posedge core_clk);
        chan_sel <= 4'($random(seed)) | 4'h1;
        run_align();
        chk("timeout", 16'h1, {15'h0, timeout});
        print_verdict();
    end
endmodule // tb_multi_tile_fifo_latency_alignment
